// >>> rtl/sttx_defines.vh
// Constants for the serial transmit and control-line block
// Operation
// R01: An operation runs only while the request bit stays set.
// R02: RTS takes the supplied level only when its write enable is set.
// R03: DTR takes the supplied level only when its write enable is set.
// R04: While break is set the transmit line is held low.
// R05: Control writes need manual modem signalling, else refused with its code.
// R06: RTS and DTR are written only on ports that have them.
// R07: Executing flag is high exactly while an operation is in progress.
// R08: Done flag is high once an operation has fully completed.
// R09: Error flag rises with done when an operation ends badly.
// R10: Status code names the failure: port, busy, faults, not configured; busy sets only the refused bit, never its code.
// R11: Control operation adds a code for writes not allowed.
// R12: Transmit ends after all bytes or on timeout, timeout being an error.
// R13: Byte count comes from the length field, at most 1024.
// R14: A zero time limit is refused with its own code.
// R15: The time limit covers the handshake phase as well as the data.
// R16: Transmit waits the requested milliseconds before the first byte.
// R17: Clear-receive option empties receive queue and FIFO before sending.
// R18: Bytes actually sent are reported; fewer only after an error; a byte cut off mid-shift by an abort is still counted.
// R19: Transmit adds codes for bad length, CTS on, CTS off, timeout.
// R20: A request while busy is refused and the running operation continues.
`ifndef STTX_DEFINES_VH
`define STTX_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STTX_ADDR_CTRL    8'h00
`define STTX_ADDR_LEN     8'h04
`define STTX_ADDR_TLIMIT  8'h08
`define STTX_ADDR_DELAY   8'h0C
`define STTX_ADDR_STATUS  8'h10
`define STTX_ADDR_CONFIG  8'h14
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define STTX_CTRL_REQ     0
`define STTX_CTRL_OP_TX   1
`define STTX_CTRL_RTS_V   2
`define STTX_CTRL_RTS_EN  3
`define STTX_CTRL_DTR_V   4
`define STTX_CTRL_DTR_EN  5
`define STTX_CTRL_BREAK   6
`define STTX_CTRL_CLR_RX  7
`define STTX_CTRL_PORT_LO 8
`define STTX_CTRL_RESET   16'h0000
// ----------------------------------------
// Config register fields
// ----------------------------------------
`define STTX_CFG_MANUAL   0
`define STTX_CFG_HSHAKE   1
`define STTX_CFG_PRESENT  2
`define STTX_CFG_RESET    3'h4
// ----------------------------------------
// Status codes
// ----------------------------------------
`define STTX_CODE_NONE        4'h0
`define STTX_CODE_BAD_PORT    4'h1
`define STTX_CODE_BUSY        4'h2
`define STTX_CODE_UART_FAULT  4'h3
`define STTX_CODE_REMOTE      4'h4
`define STTX_CODE_CTRL_REFUSE 4'h5
`define STTX_CODE_BAD_LEN     4'h6
`define STTX_CODE_BAD_TLIMIT  4'h7
`define STTX_CODE_CTS_ON      4'h8
`define STTX_CODE_CTS_OFF     4'h9
`define STTX_CODE_TX_TIMEOUT  4'hA
`define STTX_CODE_NOT_CONFIG  4'hB
// ----------------------------------------
// Limits and timing
// ----------------------------------------
`define STTX_MAX_LEN      11'h400
`define STTX_CLK_NS       10
`define STTX_MS_NS        1000000
`define STTX_BAUD_DIV     868
`endif

// >>> rtl/sttx_serial_tx.v
// Serial transmitter with control-line writes and command status
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "sttx_defines.vh"
module sttx_serial_tx #(
  parameter        PORT_ID   = 4'h0,
  parameter        HAS_CTRL  = 1,
  parameter        MS_CYCLES = `STTX_MS_NS / `STTX_CLK_NS,
  parameter        BAUD_DIV  = `STTX_BAUD_DIV
) (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [7:0]  bus_addr,
  input  wire [31:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [31:0] bus_rdata,
  input  wire [7:0]  tx_byte_data,
  input  wire        tx_byte_valid,
  output wire        tx_byte_ready,
  input  wire        cts_pin,
  input  wire        uart_fault_pin,
  input  wire        remote_fault_pin,
  output wire        txd_pin,
  output wire        rts_pin,
  output wire        dtr_pin,
  output reg         rx_flush,
  output wire        executing_flag,
  output wire        done_flag,
  output wire        error_flag
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_DELAY = 7'h02;
  localparam [6:0] ST_FLUSH = 7'h04;
  localparam [6:0] ST_CTSON = 7'h08;
  localparam [6:0] ST_SEND  = 7'h10;
  localparam [6:0] ST_CTSOF = 7'h20;
  localparam [6:0] ST_DONE  = 7'h40;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [15:0] ctrl_reg;
  reg [10:0] len_reg;
  reg [15:0] tlimit_reg;
  reg [15:0] delay_reg;
  reg [2:0]  cfg_reg;
  reg [6:0]  state_reg;
  reg [6:0]  state_next;
  reg        req_q_reg;
  reg        error_reg;
  reg [3:0]  code_reg;
  reg        refused_reg;
  reg [10:0] sent_reg;
  reg        rts_reg;
  reg        dtr_reg;
  reg        break_reg;
  reg        hs_rts_reg;
  reg [16:0] ms_cnt_reg;
  reg [15:0] dly_cnt_reg;
  reg [15:0] tmo_cnt_reg;
  reg        tmo_run_reg;
  reg [9:0]  shift_reg;
  reg [3:0]  bit_cnt_reg;
  reg [15:0] baud_cnt_reg;
  reg [2:0]  meta_reg;
  reg [2:0]  sync_reg;

  wire cts_s    = sync_reg[0];
  wire ufault_s = sync_reg[1];
  wire rfault_s = sync_reg[2];

  wire req      = ctrl_reg[`STTX_CTRL_REQ];
  wire req_rise = req & ~req_q_reg;
  wire is_tx    = ctrl_reg[`STTX_CTRL_OP_TX];
  wire hshake   = cfg_reg[`STTX_CFG_HSHAKE];
  wire ms_tick  = (ms_cnt_reg == MS_CYCLES - 1);
  wire tmo_hit  = tmo_run_reg & (tmo_cnt_reg == 16'h0000);
  wire shifter_busy = (bit_cnt_reg != 4'h0);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Common entry checks; zero means the request may proceed
  function [3:0] entry_check;
    input [3:0] port;
    input       present;
    input       uf;
    input       rf;
    begin
      if (port != PORT_ID)
        entry_check = `STTX_CODE_BAD_PORT;
      else if (!present)
        entry_check = `STTX_CODE_NOT_CONFIG;
      else if (uf)
        entry_check = `STTX_CODE_UART_FAULT;
      else if (rf)
        entry_check = `STTX_CODE_REMOTE;
      else
        entry_check = `STTX_CODE_NONE;
    end
  endfunction

  wire [3:0] base_code = entry_check(ctrl_reg[`STTX_CTRL_PORT_LO+3:`STTX_CTRL_PORT_LO],
                                     cfg_reg[`STTX_CFG_PRESENT], ufault_s, rfault_s);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
    end else begin
      meta_reg <= {remote_fault_pin, uart_fault_pin, cts_pin};
      sync_reg <= meta_reg;
    end
  end

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  wire busy_now  = (state_reg != ST_IDLE) & (state_reg != ST_DONE);
  wire ctrl_wr   = bus_wr & (bus_addr == `STTX_ADDR_CTRL);
  // Parameter writes while running would corrupt the operation, so they are dropped
  wire param_ok  = bus_wr & ~busy_now;
  wire new_req   = ctrl_wr & bus_wdata[`STTX_CTRL_REQ];

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg    <= `STTX_CTRL_RESET;
      len_reg     <= 11'h000;
      tlimit_reg  <= 16'h0000;
      delay_reg   <= 16'h0000;
      cfg_reg     <= `STTX_CFG_RESET;
      refused_reg <= 1'b0;
      bus_rdata   <= 32'h0000_0000;
    end else begin
      if (ctrl_wr && busy_now) begin
        // Only dropping the request is honoured mid-operation
        ctrl_reg[`STTX_CTRL_REQ] <= bus_wdata[`STTX_CTRL_REQ]; // see R01
      end else if (ctrl_wr) begin
        ctrl_reg <= bus_wdata[15:0];
      end
      if (param_ok && bus_addr == `STTX_ADDR_LEN)
        len_reg <= bus_wdata[10:0];
      if (param_ok && bus_addr == `STTX_ADDR_TLIMIT)
        tlimit_reg <= bus_wdata[15:0];
      if (param_ok && bus_addr == `STTX_ADDR_DELAY)
        delay_reg <= bus_wdata[15:0];
      if (param_ok && bus_addr == `STTX_ADDR_CONFIG)
        cfg_reg <= bus_wdata[2:0];
      // Refusal seen while busy wins over its clear at the next start
      if (busy_now && (new_req || (bus_wr && bus_addr != `STTX_ADDR_CTRL)))
        refused_reg <= 1'b1; // see R20
      else if (req_rise)
        refused_reg <= 1'b0;
      if (bus_rd) begin
        case (bus_addr)
          `STTX_ADDR_CTRL:   bus_rdata <= {16'h0000, ctrl_reg};
          `STTX_ADDR_LEN:    bus_rdata <= {21'h000000, len_reg};
          `STTX_ADDR_TLIMIT: bus_rdata <= {16'h0000, tlimit_reg};
          `STTX_ADDR_DELAY:  bus_rdata <= {16'h0000, delay_reg};
          `STTX_ADDR_CONFIG: bus_rdata <= {29'h00000000, cfg_reg};
          `STTX_ADDR_STATUS: bus_rdata <= {5'h00, sent_reg, 8'h00, code_reg,
                                           refused_reg, error_reg, done_flag,
                                           executing_flag};
          default:           bus_rdata <= 32'h0000_0000;
        endcase
      end else begin
        bus_rdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Millisecond base and timers
  // ----------------------------------------
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_reg  <= 17'h00000;
      dly_cnt_reg <= 16'h0000;
      tmo_cnt_reg <= 16'h0000;
      tmo_run_reg <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE || ms_tick)
        ms_cnt_reg <= 17'h00000;
      else
        ms_cnt_reg <= ms_cnt_reg + 17'h00001;
      if (state_reg == ST_IDLE)
        dly_cnt_reg <= delay_reg;
      else if (state_reg == ST_DELAY && ms_tick && dly_cnt_reg != 16'h0000)
        dly_cnt_reg <= dly_cnt_reg - 16'h0001; // see R16
      // Limit starts with the handshake, not after it
      if (state_reg == ST_FLUSH) begin
        tmo_cnt_reg <= tlimit_reg; // see R15
        tmo_run_reg <= 1'b1;
      end else if (state_reg == ST_IDLE || state_reg == ST_DONE) begin
        tmo_run_reg <= 1'b0;
      end else if (ms_tick && tmo_cnt_reg != 16'h0000) begin
        tmo_cnt_reg <= tmo_cnt_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (req_rise)
          state_next = (is_tx && base_code == `STTX_CODE_NONE &&
                        len_reg != 11'h000 && len_reg <= `STTX_MAX_LEN &&
                        tlimit_reg != 16'h0000) ? ST_DELAY : ST_DONE;
      ST_DELAY:
        if (dly_cnt_reg == 16'h0000)
          state_next = ST_FLUSH;
      ST_FLUSH:
        state_next = hshake ? ST_CTSON : ST_SEND;
      ST_CTSON:
        if (tmo_hit)
          state_next = ST_DONE;
        else if (cts_s)
          state_next = ST_SEND;
      ST_SEND:
        if (tmo_hit || ufault_s)
          state_next = ST_DONE;
        else if (sent_reg == len_reg && !shifter_busy)
          state_next = hshake ? ST_CTSOF : ST_DONE; // see R12
      ST_CTSOF:
        if (tmo_hit || !cts_s)
          state_next = ST_DONE;
      ST_DONE:
        state_next = ST_DONE;
      default:
        state_next = ST_IDLE;
    endcase
    // Dropping the request abandons or closes any operation
    if (!req)
      state_next = ST_IDLE; // see R01
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_IDLE;
      req_q_reg  <= 1'b0;
      error_reg  <= 1'b0;
      code_reg   <= `STTX_CODE_NONE;
      rts_reg    <= 1'b0;
      dtr_reg    <= 1'b0;
      break_reg  <= 1'b0;
      hs_rts_reg <= 1'b0;
      rx_flush   <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_q_reg <= req;
      rx_flush  <= 1'b0;
      if (state_reg == ST_IDLE && req_rise) begin
        error_reg <= 1'b0;
        code_reg  <= `STTX_CODE_NONE;
        if (base_code != `STTX_CODE_NONE) begin
          error_reg <= 1'b1; // see R09
          code_reg  <= base_code; // see R10
        end else if (!is_tx && !cfg_reg[`STTX_CFG_MANUAL]) begin
          error_reg <= 1'b1;
          code_reg  <= `STTX_CODE_CTRL_REFUSE; // see R05, R11
        end else if (!is_tx) begin
          if (HAS_CTRL != 0 && ctrl_reg[`STTX_CTRL_RTS_EN])
            rts_reg <= ctrl_reg[`STTX_CTRL_RTS_V]; // see R02, R06
          if (HAS_CTRL != 0 && ctrl_reg[`STTX_CTRL_DTR_EN])
            dtr_reg <= ctrl_reg[`STTX_CTRL_DTR_V]; // see R03, R06
          break_reg <= ctrl_reg[`STTX_CTRL_BREAK];
        end else if (len_reg == 11'h000 || len_reg > `STTX_MAX_LEN) begin
          error_reg <= 1'b1;
          code_reg  <= `STTX_CODE_BAD_LEN; // see R13, R19
        end else if (tlimit_reg == 16'h0000) begin
          error_reg <= 1'b1;
          code_reg  <= `STTX_CODE_BAD_TLIMIT; // see R14
        end
      end
      if (state_reg == ST_FLUSH) begin
        rx_flush   <= ctrl_reg[`STTX_CTRL_CLR_RX]; // see R17
        hs_rts_reg <= hshake;
      end
      if (state_reg == ST_CTSON && tmo_hit) begin
        error_reg <= 1'b1;
        code_reg  <= `STTX_CODE_CTS_ON; // see R19
      end
      if (state_reg == ST_SEND && tmo_hit) begin
        error_reg <= 1'b1;
        code_reg  <= `STTX_CODE_TX_TIMEOUT; // see R12, R19
      end else if (state_reg == ST_SEND && ufault_s) begin
        error_reg <= 1'b1;
        code_reg  <= `STTX_CODE_UART_FAULT;
      end
      if (state_reg == ST_SEND && state_next == ST_CTSOF)
        hs_rts_reg <= 1'b0;
      if (state_reg == ST_CTSOF && tmo_hit && cts_s) begin
        error_reg <= 1'b1;
        code_reg  <= `STTX_CODE_CTS_OFF; // see R19
      end
      if (state_next == ST_IDLE || state_next == ST_DONE)
        hs_rts_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Byte serializer, 8N1
  // ----------------------------------------
  // Source stalls freely; a byte is taken only when the shifter is empty
  assign tx_byte_ready = (state_reg == ST_SEND) & ~shifter_busy &
                         (sent_reg != len_reg) & ~tmo_hit & ~ufault_s;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg    <= 10'h3FF;
      bit_cnt_reg  <= 4'h0;
      baud_cnt_reg <= 16'h0000;
      sent_reg     <= 11'h000;
    end else begin
      if (state_reg == ST_IDLE && req_rise) begin
        sent_reg <= 11'h000;
      end else if (tx_byte_ready && tx_byte_valid) begin
        shift_reg    <= {1'b1, tx_byte_data, 1'b0};
        bit_cnt_reg  <= 4'hA;
        baud_cnt_reg <= BAUD_DIV[15:0] - 16'h0001;
        sent_reg     <= sent_reg + 11'h001; // see R13, R18
      end else if (state_reg != ST_SEND && state_reg != ST_CTSOF) begin
        // Abort drops a partly shifted byte; it is still counted
        bit_cnt_reg <= 4'h0;
        shift_reg   <= 10'h3FF;
      end else if (shifter_busy) begin
        if (baud_cnt_reg == 16'h0000) begin
          baud_cnt_reg <= BAUD_DIV[15:0] - 16'h0001;
          bit_cnt_reg  <= bit_cnt_reg - 4'h1;
          shift_reg    <= {1'b1, shift_reg[9:1]};
        end else begin
          baud_cnt_reg <= baud_cnt_reg - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign txd_pin        = break_reg ? 1'b0 : shift_reg[0]; // see R04
  assign rts_pin        = hshake ? hs_rts_reg : rts_reg;
  assign dtr_pin        = dtr_reg;
  assign executing_flag = busy_now; // see R07
  assign done_flag      = (state_reg == ST_DONE); // see R08
  assign error_flag     = done_flag & error_reg; // see R09
endmodule // sttx_serial_tx
`default_nettype wire

// >>> tb/sttx_serial_tx_props.sv
// Checker watching the serial transmit block ports
`timescale 1ns/10ps
`default_nettype none
`include "sttx_defines.vh"
module sttx_serial_tx_chk (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [7:0]  bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [7:0]  tx_byte_data,
  input wire logic        tx_byte_valid,
  input wire logic        tx_byte_ready,
  input wire logic        cts_pin,
  input wire logic        uart_fault_pin,
  input wire logic        remote_fault_pin,
  input wire logic        txd_pin,
  input wire logic        rts_pin,
  input wire logic        dtr_pin,
  input wire logic        rx_flush,
  input wire logic        executing_flag,
  input wire logic        done_flag,
  input wire logic        error_flag
);
  // ----
  // Clocking
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Fresh control op only, a write while busy must not count
  wire ctl_go = bus_wr && bus_addr == `STTX_ADDR_CTRL && bus_wdata[1:0] == 2'h1
    && !executing_flag && !done_flag;
  // ----
  // Properties
  // ----
  property p_ctrl_done;
    ctl_go |-> ##[1:3] done_flag;
  endproperty
  a_ctrl_done: assert property (p_ctrl_done) else $error("control op late");
  property p_rts;
    !$stable(rts_pin) |-> $past(bus_wr) || $past(bus_wr, 2) || $past(bus_wr, 3) ||
      $past(executing_flag);
  endproperty
  a_rts: assert property (p_rts) else $error("rts moved on its own");
  property p_dtr;
    !$stable(dtr_pin) |-> $past(bus_wr, 2) || $past(bus_wr, 3);
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr moved on its own");
  property p_excl;
    done_flag |-> !executing_flag;
  endproperty
  a_excl: assert property (p_excl) else $error("done while executing");
  property p_err;
    error_flag |-> done_flag;
  endproperty
  a_err: assert property (p_err) else $error("error without done");
  property p_code;
    $past(bus_rd) && $past(bus_addr) == `STTX_ADDR_STATUS && bus_rdata[1]
      |-> bus_rdata[2] == (bus_rdata[7:4] != 4'h0);
  endproperty
  a_code: assert property (p_code) else $error("code and error disagree");
  property p_rdata;
    !$past(bus_rd) |-> bus_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  property p_flush;
    rx_flush |-> executing_flag ##1 !rx_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse wrong");
  property p_ready;
    tx_byte_ready |-> executing_flag && !done_flag;
  endproperty
  a_ready: assert property (p_ready) else $error("byte taken while idle");
endmodule // sttx_serial_tx_chk
bind sttx_serial_tx sttx_serial_tx_chk sttx_serial_tx_chk_inst (.clk_sys, .reset_n,
  .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .tx_byte_data, .tx_byte_valid,
  .tx_byte_ready, .cts_pin, .uart_fault_pin, .remote_fault_pin, .txd_pin, .rts_pin,
  .dtr_pin, .rx_flush, .executing_flag, .done_flag, .error_flag);
`default_nettype wire

// >>> tb/sttx_peer.sv
// Behavioural serial peer: CTS answer and frame decoder
`timescale 1ns/10ps
`default_nettype none
module sttx_peer #(
  parameter int BAUD_DIV = 4
) (
  input  wire logic       clk_sys,
  input  wire logic       txd_pin,
  input  wire logic       rts_pin,
  input  wire logic [1:0] cts_mode,
  output var  logic       cts_pin
);
  logic [7:0] rts_hist = 8'h00;
  logic [7:0] rx_q[$];
  always @(posedge clk_sys) begin
    rts_hist <= {rts_hist[6:0], rts_pin};
  end
  // Mode 0 prompt, 1 slow, 2 stuck low, 3 stuck high
  always @* begin
    case (cts_mode)
      2'h0: cts_pin = rts_pin;
      2'h1: cts_pin = rts_hist[7];
      2'h2: cts_pin = 1'h0;
      default: cts_pin = 1'h1;
    endcase
  end
  // Frames kept only with a good stop bit, so a break leaves no byte
  initial begin : rx_b
    logic [7:0] b;
    forever begin
      @(negedge txd_pin);
      repeat (BAUD_DIV / 2) @(negedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(negedge clk_sys);
        b[i] = txd_pin;
      end
      repeat (BAUD_DIV) @(negedge clk_sys);
      if (txd_pin === 1'h1) rx_q.push_back(b);
    end
  end
endmodule // sttx_peer
`default_nettype wire

// >>> tb/test_serial_tx_and_control_lines.sv
// Self-checking testbench for the serial transmit block
`timescale 1ns/10ps
`default_nettype none
`include "sttx_defines.vh"
module test_serial_tx_and_control_lines;
  localparam int MS = 10;
  localparam logic [3:0] P = 4'h2;
  logic        clk_sys = 1'h0;
  logic        reset_n = 1'h0;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'h0;
  logic        bus_rd = 1'h0;
  logic [7:0]  tx_byte_data = 8'h00;
  logic        tx_byte_valid = 1'h0;
  logic        uart_fault_pin = 1'h0;
  logic        remote_fault_pin = 1'h0;
  logic [1:0]  cts_mode = 2'h0;
  logic        feed = 1'h0;
  logic        arm = 1'h0;
  logic [31:0] bus_rdata, d;
  logic        tx_byte_ready, cts_pin, txd_pin, rts_pin, dtr_pin;
  logic        rx_flush, executing_flag, done_flag, error_flag;
  int          bad_count = 0;
  int          tests_run = 0;
  int          flushes = 0;
  int          cyc = 0;
  int          t_low = 0;
  logic [7:0]  src_q[$];
  logic [7:0]  exp_q[$];
  logic [3:0]  ec[4] = '{`STTX_CODE_BAD_PORT, `STTX_CODE_NOT_CONFIG,
                         `STTX_CODE_UART_FAULT, `STTX_CODE_REMOTE};
  sttx_serial_tx #(.PORT_ID(P), .MS_CYCLES(MS), .BAUD_DIV(4)) sttx_serial_tx_inst (
    .clk_sys, .reset_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .tx_byte_data, .tx_byte_valid, .tx_byte_ready, .cts_pin, .uart_fault_pin,
    .remote_fault_pin, .txd_pin, .rts_pin, .dtr_pin, .rx_flush, .executing_flag,
    .done_flag, .error_flag);
  sttx_peer #(.BAUD_DIV(4)) sttx_peer_inst (.clk_sys, .txd_pin, .rts_pin, .cts_mode,
    .cts_pin);
  always #5 clk_sys = ~clk_sys;
  // ----
  // Byte feeder and monitors
  // ----
  always @(posedge clk_sys) begin
    cyc++;
    if (rx_flush === 1'h1) flushes++;
    if (arm && txd_pin === 1'h0) begin
      t_low = cyc;
      arm <= 1'h0;
    end
    if (tx_byte_valid && tx_byte_ready) void'(src_q.pop_front());
    tx_byte_valid <= feed && src_q.size() > 0;
    // Idle data keeps moving so a stale byte cannot pass
    tx_byte_data <= src_q.size() > 0 ? src_q[0] : ~tx_byte_data;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkb(input string s, input logic e, input logic g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'h1;
    @(posedge clk_sys);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge clk_sys);
    bus_rd <= 1'h0;
    #1 v = bus_rdata;
  endtask
  function automatic logic [31:0] cw(input logic [6:0] f, input logic [3:0] p);
    return {20'h00000, p, f, 1'h1};
  endfunction
  task automatic run(input logic [31:0] c, input logic [3:0] code, input logic [10:0] n,
                     input logic poke);
    logic r;
    r = poke;
    wr(`STTX_ADDR_CTRL, c);
    for (int k = 0; k < 3000 && done_flag !== 1'h1; k++) begin
      @(negedge clk_sys);
      if (poke && executing_flag === 1'h1) begin
        wr(`STTX_ADDR_CTRL, cw(7'h06, P));
        poke = 1'h0;
      end
    end
    chkb("done", 1'h1, done_flag);
    chkb("error", code != 4'h0, error_flag);
    rd(`STTX_ADDR_STATUS, d);
    chk("status", {5'h00, n, 8'h00, code, r, code != 4'h0, 2'h2}, d);
    wr(`STTX_ADDR_CTRL, c & 32'hFFFFFFFE);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin : wd_b
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
  // ----
  // Main sequence
  // ----
  initial begin : main_b
    logic [6:0] f;
    logic       er, ed;
    int         n, t0;
    er = 1'h0;
    ed = 1'h0;
    void'($urandom(32'hE1385047));
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'h1;
    chkb("txd", 1'h1, txd_pin);
    rd(`STTX_ADDR_CONFIG, d);
    chk("config", 32'h4, d);
    rd(8'h3C, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    run(cw(7'h06, P), `STTX_CODE_CTRL_REFUSE, 11'h0, 1'h0);
    chkb("rts", 1'h0, rts_pin);
    wr(`STTX_ADDR_CONFIG, 32'h5);
    repeat (10) begin
      f = 7'($urandom) & 7'h3E;
      if (f[2]) er = f[1];
      if (f[4]) ed = f[3];
      run(cw(f, P), `STTX_CODE_NONE, 11'h0, 1'h0);
      chkb("rts", er, rts_pin);
      chkb("dtr", ed, dtr_pin);
      chkb("txd", ~f[5], txd_pin);
    end
    run(cw(7'h00, P), `STTX_CODE_NONE, 11'h0, 1'h0);
    $display("test control writes done");
    for (int i = 0; i < 4; i++) begin
      uart_fault_pin <= i == 2;
      remote_fault_pin <= i == 3;
      wr(`STTX_ADDR_CONFIG, i == 1 ? 32'h1 : 32'h5);
      repeat (3) @(posedge clk_sys);
      run(cw({4'h0, 1'h1, ~er, 1'h0}, i == 0 ? 4'h5 : P), ec[i], 11'h0, 1'h0);
      chkb("rts", er, rts_pin);
    end
    uart_fault_pin <= 1'h0;
    remote_fault_pin <= 1'h0;
    wr(`STTX_ADDR_CONFIG, 32'h5);
    for (int i = 0; i < 3; i++) begin
      wr(`STTX_ADDR_LEN, i == 0 ? 32'h0 : i == 1 ? 32'h401 : 32'h1);
      wr(`STTX_ADDR_TLIMIT, i == 2 ? 32'h0 : 32'h32);
      run(cw(7'h01, P), i == 2 ? `STTX_CODE_BAD_TLIMIT : `STTX_CODE_BAD_LEN, 11'h0,
          1'h0);
    end
    $display("test refusals done");
    feed <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      n = 1 + $urandom % 4;
      wr(`STTX_ADDR_CONFIG, k == 2 ? 32'h7 : 32'h5);
      cts_mode <= k == 2 ? 2'h1 : 2'h0;
      wr(`STTX_ADDR_LEN, n);
      wr(`STTX_ADDR_TLIMIT, 32'h32);
      wr(`STTX_ADDR_DELAY, k);
      repeat (n) src_q.push_back(8'($urandom));
      exp_q = src_q;
      sttx_peer_inst.rx_q.delete();
      flushes = 0;
      t0 = cyc;
      arm <= 1'h1;
      run(cw({k == 1, 5'h00, 1'h1}, P), `STTX_CODE_NONE, 11'(n), k == 1);
      chk("bytes", n, sttx_peer_inst.rx_q.size());
      foreach (exp_q[j]) chk("byte", exp_q[j], sttx_peer_inst.rx_q[j]);
      chk("flush", k == 1, flushes);
      chkb("delay", 1'h1, t_low - t0 >= k * MS);
    end
    $display("test transmit done");
    wr(`STTX_ADDR_CONFIG, 32'h7);
    wr(`STTX_ADDR_LEN, 32'h1);
    wr(`STTX_ADDR_TLIMIT, 32'h14);
    for (int i = 0; i < 2; i++) begin
      cts_mode <= i == 1 ? 2'h3 : 2'h2;
      src_q.push_back(8'h5A);
      run(cw(7'h01, P), i == 1 ? `STTX_CODE_CTS_OFF : `STTX_CODE_CTS_ON, 11'(i),
          1'h0);
      src_q.delete();
    end
    cts_mode <= 2'h0;
    feed <= 1'h0;
    wr(`STTX_ADDR_CONFIG, 32'h5);
    wr(`STTX_ADDR_LEN, 32'h3);
    wr(`STTX_ADDR_TLIMIT, 32'h3);
    repeat (3) src_q.push_back(8'h3C);
    run(cw(7'h01, P), `STTX_CODE_TX_TIMEOUT, 11'h0, 1'h0);
    $display("test timeouts done");
    final_report();
  end
endmodule // test_serial_tx_and_control_lines
`default_nettype wire
